// ==== rtl/spw_top.sv ====
// How it works
// - Each channel counts up to period, wraps
// - Outputs low at count start and stop
// - Outputs forced low at period end
// - First output high on first compare
// - Second output high on second compare
// - Start bits start channels same cycle
// - Stop bits halt channels together
// - Clear bits zero counters together
// - Command registers shared across all channels
// - Zero bits change nothing
// - CPU write beats hardware start/stop
// - Hardware start/stop via source selects
`timescale 1ns/10ps
`default_nettype none
module spw_top
    import spw_pkg::*;
#(
    parameter int NUM_CH = SPW_NUM_CH,
    parameter int CNT_W = SPW_CNT_W
) (
    // Clock, reset, enable
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic CLK_EN_I,
    // APB slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // Hardware start/stop request sources
    input wire logic [NUM_CH-1:0] HW_START_REQ_I,
    input wire logic [NUM_CH-1:0] HW_STOP_REQ_I,
    // PWM pins
    output logic [NUM_CH-1:0] PWM_PIN_FIRST_O,
    output logic [NUM_CH-1:0] PWM_PIN_SECOND_O
);

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic wr_en;
    logic rd_en;
    logic [NUM_CH-1:0] sw_start_cmd_reg;
    logic [NUM_CH-1:0] sw_stop_cmd_reg;
    logic [NUM_CH-1:0] sw_clear_cmd_reg;
    logic [NUM_CH-1:0] hw_start_source_sel;
    logic [NUM_CH-1:0] hw_stop_source_sel;
    logic [NUM_CH-1:0] running_reg;
    logic [CNT_W-1:0] period_reg [NUM_CH];
    logic [CNT_W-1:0] duty_a_reg [NUM_CH];
    logic [CNT_W-1:0] duty_b_reg [NUM_CH];
    logic [CNT_W-1:0] count_reg [NUM_CH];
    logic [11:0] ch_rel;
    logic [1:0] ch_idx;
    logic [1:0] ch_word;
    logic ch_hit;
    logic glob_hit;
    logic addr_ok;
    logic [31:0] rd_data;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Single-cycle access phase, no wait states
    assign PREADY_O = 1'b1;
    assign wr_en = PSEL_I && PENABLE_I && PWRITE_I && CLK_EN_I;
    assign rd_en = PSEL_I && PENABLE_I && !PWRITE_I;
    assign ch_rel = PADDR_I - SPW_OFF_CH_BASE;
    assign ch_idx = ch_rel[5:4];
    assign ch_word = ch_rel[3:2];
    assign ch_hit = (PADDR_I >= SPW_OFF_CH_BASE) &&
                    (ch_rel < 12'(NUM_CH) * SPW_OFF_CH_STRIDE) && (PADDR_I[1:0] == 2'h0);
    assign glob_hit = (PADDR_I <= SPW_OFF_HW_STOP_SEL) && (PADDR_I[1:0] == 2'h0);
    assign addr_ok = ch_hit || glob_hit;

    // ------------------------------------------------------------
    // Error response
    // ------------------------------------------------------------
    // Unmapped or misaligned access answers with an error
    assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_ok;

    // ------------------------------------------------------------
    // Command strobes
    // ------------------------------------------------------------
    // Command strobes: a write pulse, bit 1 acts, bit 0 ignored
    always_comb begin
        sw_start_cmd_reg = '0;
        sw_stop_cmd_reg = '0;
        sw_clear_cmd_reg = '0;
        if (wr_en) begin
            // Shared registers, one write reaches every channel
            if (PADDR_I == SPW_OFF_START) begin
                sw_start_cmd_reg = PWDATA_I[NUM_CH-1:0];
            end
            if (PADDR_I == SPW_OFF_STOP) begin
                sw_stop_cmd_reg = PWDATA_I[NUM_CH-1:0];
            end
            if (PADDR_I == SPW_OFF_CLEAR) begin
                sw_clear_cmd_reg = PWDATA_I[NUM_CH-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Source select registers
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            hw_start_source_sel <= NUM_CH'(SPW_RST_SEL);
            hw_stop_source_sel <= NUM_CH'(SPW_RST_SEL);
        end else if (wr_en) begin
            if (PADDR_I == SPW_OFF_HW_START_SEL) begin
                hw_start_source_sel <= PWDATA_I[NUM_CH-1:0];
            end
            if (PADDR_I == SPW_OFF_HW_STOP_SEL) begin
                hw_stop_source_sel <= PWDATA_I[NUM_CH-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : gen_ch
            logic cpu_start;
            logic cpu_stop;
            logic hw_start;
            logic hw_stop;
            logic run_next;
            logic cfg_wr;
            logic period_wr;
            logic duty_a_wr;
            logic duty_b_wr;
            logic count_wr;
            logic at_end;
            logic run_edge;
            logic hit_a;
            logic hit_b;
            logic [CNT_W-1:0] count_next;
            logic pin_first_next;
            logic pin_second_next;

            // ----------------------------------------------------
            // Request decode
            // ----------------------------------------------------
            assign cpu_start = sw_start_cmd_reg[g];
            assign cpu_stop = sw_stop_cmd_reg[g];
            assign hw_start = HW_START_REQ_I[g] && hw_start_source_sel[g];
            assign hw_stop = HW_STOP_REQ_I[g] && hw_stop_source_sel[g];
            assign cfg_wr = wr_en && ch_hit && (ch_idx == 2'(g));
            assign period_wr = cfg_wr && (ch_word == SPW_CH_PERIOD);
            assign duty_a_wr = cfg_wr && (ch_word == SPW_CH_DUTY_A);
            assign duty_b_wr = cfg_wr && (ch_word == SPW_CH_DUTY_B);
            assign count_wr = cfg_wr && (ch_word == SPW_CH_COUNT);
            // Compare >= so a period lowered below the count still wraps
            assign at_end = (count_reg[g] >= period_reg[g]);
            assign hit_a = (count_reg[g] == duty_a_reg[g]);
            assign hit_b = (count_reg[g] == duty_b_reg[g]);
            assign run_edge = (run_next != running_reg[g]);

            // ----------------------------------------------------
            // Run control
            // ----------------------------------------------------
            // CPU write overrides any hardware request in the same cycle
            always_comb begin
                run_next = running_reg[g];
                if (cpu_start || cpu_stop) begin
                    run_next = cpu_start && !cpu_stop;
                end else if (hw_start || hw_stop) begin
                    run_next = hw_start && !hw_stop;
                end
            end

            always_ff @(posedge REF_CLK_I) begin
                if (RST_I) begin
                    running_reg[g] <= 1'b0;
                end else if (CLK_EN_I) begin
                    running_reg[g] <= run_next;
                end
            end

            // ----------------------------------------------------
            // Configuration registers
            // ----------------------------------------------------
            always_ff @(posedge REF_CLK_I) begin
                if (RST_I) begin
                    period_reg[g] <= CNT_W'(SPW_RST_PERIOD);
                end else if (period_wr) begin
                    period_reg[g] <= PWDATA_I[CNT_W-1:0];
                end
            end

            always_ff @(posedge REF_CLK_I) begin
                if (RST_I) begin
                    duty_a_reg[g] <= CNT_W'(SPW_RST_DUTY);
                end else if (duty_a_wr) begin
                    duty_a_reg[g] <= PWDATA_I[CNT_W-1:0];
                end
            end

            always_ff @(posedge REF_CLK_I) begin
                if (RST_I) begin
                    duty_b_reg[g] <= CNT_W'(SPW_RST_DUTY);
                end else if (duty_b_wr) begin
                    duty_b_reg[g] <= PWDATA_I[CNT_W-1:0];
                end
            end

            // ----------------------------------------------------
            // Counter
            // ----------------------------------------------------
            // Clear wins over count; running state left alone by clear
            always_comb begin
                count_next = count_reg[g];
                if (sw_clear_cmd_reg[g]) begin
                    count_next = '0;
                end else if (count_wr) begin
                    count_next = PWDATA_I[CNT_W-1:0];
                end else if (running_reg[g]) begin
                    if (at_end) begin
                        count_next = '0;
                    end else begin
                        count_next = count_reg[g] + 1'b1;
                    end
                end
            end

            always_ff @(posedge REF_CLK_I) begin
                if (RST_I) begin
                    count_reg[g] <= CNT_W'(SPW_RST_COUNT);
                end else if (CLK_EN_I) begin
                    count_reg[g] <= count_next;
                end
            end

            // ----------------------------------------------------
            // Output pins
            // ----------------------------------------------------
            // Low on start/stop edge and at cycle end
            always_comb begin
                pin_first_next = PWM_PIN_FIRST_O[g];
                pin_second_next = PWM_PIN_SECOND_O[g];
                if (run_edge) begin
                    pin_first_next = 1'b0;
                    pin_second_next = 1'b0;
                end else if (running_reg[g]) begin
                    if (at_end) begin
                        pin_first_next = 1'b0;
                        pin_second_next = 1'b0;
                    end else begin
                        if (hit_a) begin
                            pin_first_next = 1'b1;
                        end
                        if (hit_b) begin
                            pin_second_next = 1'b1;
                        end
                    end
                end
            end

            always_ff @(posedge REF_CLK_I) begin
                if (RST_I) begin
                    PWM_PIN_FIRST_O[g] <= 1'b0;
                    PWM_PIN_SECOND_O[g] <= 1'b0;
                end else if (CLK_EN_I) begin
                    PWM_PIN_FIRST_O[g] <= pin_first_next;
                    PWM_PIN_SECOND_O[g] <= pin_second_next;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [31:0] ch_rd_data;
    logic [31:0] glob_rd_data;

    always_comb begin
        ch_rd_data = '0;
        case (ch_word)
            SPW_CH_PERIOD: ch_rd_data[CNT_W-1:0] = period_reg[ch_idx];
            SPW_CH_DUTY_A: ch_rd_data[CNT_W-1:0] = duty_a_reg[ch_idx];
            SPW_CH_DUTY_B: ch_rd_data[CNT_W-1:0] = duty_b_reg[ch_idx];
            default: ch_rd_data[CNT_W-1:0] = count_reg[ch_idx];
        endcase
    end

    // Command registers read back as zero, they store nothing
    always_comb begin
        glob_rd_data = '0;
        case (PADDR_I)
            SPW_OFF_STATUS: glob_rd_data[NUM_CH-1:0] = running_reg;
            SPW_OFF_HW_START_SEL: glob_rd_data[NUM_CH-1:0] = hw_start_source_sel;
            SPW_OFF_HW_STOP_SEL: glob_rd_data[NUM_CH-1:0] = hw_stop_source_sel;
            default: glob_rd_data = '0;
        endcase
    end

    assign rd_data = ch_hit ? ch_rd_data : glob_rd_data;

    // ------------------------------------------------------------
    // Read data register
    // ------------------------------------------------------------
    // Captured in setup so the word stands through the access phase
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            PRDATA_O <= '0;
        end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
            PRDATA_O <= rd_data;
        end
    end

    logic unused_rd;
    assign unused_rd = rd_en;

endmodule : spw_top
`default_nettype wire

// ==== rtl/spw_pkg.sv ====
package spw_pkg;
    // Channel count and counter width
    localparam int SPW_NUM_CH = 4;
    localparam int SPW_CNT_W = 32;
    // Register byte offsets, shared command registers first
    localparam logic [11:0] SPW_OFF_START = 12'h000;
    localparam logic [11:0] SPW_OFF_STOP = 12'h004;
    localparam logic [11:0] SPW_OFF_CLEAR = 12'h008;
    localparam logic [11:0] SPW_OFF_STATUS = 12'h00c;
    localparam logic [11:0] SPW_OFF_HW_START_SEL = 12'h010;
    localparam logic [11:0] SPW_OFF_HW_STOP_SEL = 12'h014;
    localparam logic [11:0] SPW_OFF_CH_BASE = 12'h040;
    localparam logic [11:0] SPW_OFF_CH_STRIDE = 12'h010;
    // Per-channel word index within a channel block
    localparam logic [1:0] SPW_CH_PERIOD = 2'h0;
    localparam logic [1:0] SPW_CH_DUTY_A = 2'h1;
    localparam logic [1:0] SPW_CH_DUTY_B = 2'h2;
    localparam logic [1:0] SPW_CH_COUNT = 2'h3;
    // Reset values
    localparam logic [31:0] SPW_RST_PERIOD = 32'hffff_ffff;
    localparam logic [31:0] SPW_RST_DUTY = 32'hffff_ffff;
    localparam logic [31:0] SPW_RST_COUNT = 32'h0000_0000;
    localparam logic [3:0] SPW_RST_SEL = 4'h0;
endpackage : spw_pkg

// ==== testbench/spw_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module spw_checker
    import spw_pkg::*;
#(
    parameter int NUM_CH = SPW_NUM_CH
) (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic CLK_EN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic [NUM_CH-1:0] PWM_PIN_FIRST_O,
    input wire logic [NUM_CH-1:0] PWM_PIN_SECOND_O
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    logic acc, mapped, stop_wr;
    logic [NUM_CH-1:0] stop_mask, pins;
    assign acc = PSEL_I && PENABLE_I;
    assign pins = PWM_PIN_FIRST_O | PWM_PIN_SECOND_O;
    assign mapped = (PADDR_I[1:0] == 2'h0) && (PADDR_I < 12'h018 || (PADDR_I >= SPW_OFF_CH_BASE
        && PADDR_I < SPW_OFF_CH_BASE + 12'(NUM_CH) * SPW_OFF_CH_STRIDE));
    assign stop_wr = acc && PWRITE_I && CLK_EN_I && PADDR_I == SPW_OFF_STOP;
    // Mask held so the check outlives the bus write
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            stop_mask <= '0;
        end else if (stop_wr) begin
            stop_mask <= PWDATA_I[NUM_CH-1:0];
        end
    end
    a_ready_high: assert property (PREADY_O == 1'b1) else $error("pready low");
    a_slverr_bad: assert property (acc && !mapped |-> PSLVERR_O) else $error("no slverr");
    a_slverr_good: assert property (acc && mapped |-> !PSLVERR_O) else $error("bad slverr");
    a_unmapped_rd: assert property (acc && !PWRITE_I && !mapped |-> PRDATA_O == 32'h0)
        else $error("unmapped read not zero");
    a_cmd_reads_zero: assert property (acc && !PWRITE_I && PADDR_I < SPW_OFF_STATUS
        |-> PRDATA_O == 32'h0) else $error("command register read not zero");
    a_rst_pins_low: assert property ($fell(RST_I) |-> pins == '0) else $error("pins after reset");
    a_stop_pins_low: assert property (stop_wr |=> ##1 ((pins & stop_mask) == '0) [*4])
        else $error("pins active after stop");
    a_freeze_pins: assert property (!CLK_EN_I |=> $stable(pins)) else $error("pins moved");
    c_stop: cover property (stop_wr);
    c_unmapped: cover property (acc && !mapped);
    c_pin_rise: cover property ($rose(PWM_PIN_FIRST_O[0]));
endmodule : spw_checker
bind spw_top spw_checker #(.NUM_CH(NUM_CH)) u_chk (.REF_CLK_I, .RST_I, .CLK_EN_I, .PSEL_I,
    .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O,
    .PWM_PIN_FIRST_O, .PWM_PIN_SECOND_O);
`default_nettype wire

// ==== testbench/spw_cpu_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module spw_cpu_model
    import spw_pkg::*;
#(
    parameter int TRIG_CYC = 40
) (
    // Clock and answer
    input wire logic clk_i,
    input wire logic pready_i,
    // Bus request
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [11:0] paddr_o,
    output logic [31:0] pwdata_o,
    output logic hang_o
);
    initial begin
        {psel_o, penable_o, pwrite_o, hang_o} = 4'h0;
        paddr_o = 12'h0;
        pwdata_o = 32'h0;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} <= {2'b10, w, a, d};
        @(posedge clk_i);
        penable_o <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_i !== 1'b1 && n < 50);
        if (n == 50) hang_o <= 1'b1;
        {psel_o, penable_o} <= 2'b00;
    endtask : xfer
    // Trigger period shortened; starts after TRIG_CYC ticks, counts zeroed first
    task automatic start_all();
        repeat (TRIG_CYC) @(posedge clk_i);
        for (int c = 0; c < 4; c++) begin
            xfer(1'b1, SPW_OFF_CH_BASE + 12'(c) * SPW_OFF_CH_STRIDE + {8'h0, SPW_CH_COUNT, 2'b00},
                32'h0);
        end
        xfer(1'b1, SPW_OFF_START, 32'h0000_000f);
    endtask : start_all
    task automatic stop_clear_all();
        repeat (2 * TRIG_CYC) @(posedge clk_i);
        xfer(1'b1, SPW_OFF_STOP, 32'h0000_000f);
        xfer(1'b1, SPW_OFF_CLEAR, 32'h0000_000f);
    endtask : stop_clear_all
endmodule : spw_cpu_model
`default_nettype wire

// ==== testbench/spw_top_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module spw_top_tb_top
    import spw_pkg::*;
;
    localparam int P = 9;
    logic clk = 0, rst = 1, clk_en = 1, psel, penable, pwrite, pready, slverr, hang;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, exp_q[$], da[4], db[4];
    logic [3:0] hw_sta = 4'h0, hw_stp = 4'h0, pin_a, pin_b;
    int n_fail = 0, cmp_count = 0, seed = 95, cyc = 0;
    always #50 clk = ~clk;
    spw_top u_dut (.REF_CLK_I(clk), .RST_I(rst), .CLK_EN_I(clk_en), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(slverr), .HW_START_REQ_I(hw_sta),
        .HW_STOP_REQ_I(hw_stp), .PWM_PIN_FIRST_O(pin_a), .PWM_PIN_SECOND_O(pin_b));
    spw_cpu_model u_cpu (.clk_i(clk), .pready_i(pready), .psel_o(psel), .penable_o(penable),
        .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .hang_o(hang));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
        cmp_count++;
        if (seen !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, seen);
        end
    endtask : chk
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    function automatic logic [11:0] cha(input int c, input logic [1:0] w);
        return SPW_OFF_CH_BASE + 12'(c * 16) + {8'h0, w, 2'b00};
    endfunction : cha
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        u_cpu.xfer(1'b0, a, 32'h0);
    endtask : rd
    // High time over whole periods is phase independent
    task automatic meas(input bit run);
        int ha[4], hb[4];
        ha = '{default: 0};
        hb = '{default: 0};
        repeat (P + 3) @(negedge clk);
        repeat (4 * (P + 1)) begin
            @(negedge clk);
            for (int c = 0; c < 4; c++) begin
                ha[c] += pin_a[c];
                hb[c] += pin_b[c];
            end
        end
        for (int c = 0; c < 4; c++) begin
            chk("pin_first_high", ha[c], run ? 4 * (P - da[c]) : 0);
            chk("pin_second_high", hb[c], run ? 4 * (P - db[c]) : 0);
        end
    endtask : meas
    always @(posedge clk) begin
        cyc++;
        if (psel && penable && !pwrite && pready === 1'b1) begin
            if (exp_q.size() == 0) chk("unexpected_read", 32'h1, 32'h0);
            else chk("prdata", prdata, exp_q.pop_front());
        end
        if (hang || cyc > 20000) begin
            n_fail++;
            give_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            rd(cha(c, SPW_CH_PERIOD), SPW_RST_PERIOD);
            rd(cha(c, SPW_CH_DUTY_B), SPW_RST_DUTY);
            rd(cha(c, SPW_CH_COUNT), SPW_RST_COUNT);
            da[c] = 1 + {$random(seed)} % (P - 1);
            db[c] = 1 + {$random(seed)} % (P - 1);
            u_cpu.xfer(1'b1, cha(c, SPW_CH_PERIOD), P);
            u_cpu.xfer(1'b1, cha(c, SPW_CH_DUTY_A), da[c]);
            u_cpu.xfer(1'b1, cha(c, SPW_CH_DUTY_B), db[c]);
        end
        rd(SPW_OFF_HW_START_SEL, {28'h0, SPW_RST_SEL});
        rd(12'h020, 32'h0);
        repeat (2) begin
            u_cpu.start_all();
            rd(SPW_OFF_STATUS, 32'hf);
            meas(1'b1);
            u_cpu.stop_clear_all();
            rd(SPW_OFF_STATUS, 32'h0);
            for (int c = 0; c < 4; c++) rd(cha(c, SPW_CH_COUNT), 32'h0);
            meas(1'b0);
        end
        u_cpu.xfer(1'b1, SPW_OFF_START, 32'h5);
        u_cpu.xfer(1'b1, SPW_OFF_START, 32'h0);
        u_cpu.xfer(1'b1, SPW_OFF_STOP, 32'h2);
        rd(SPW_OFF_STATUS, 32'h5);
        u_cpu.xfer(1'b1, SPW_OFF_STOP, 32'h1);
        u_cpu.xfer(1'b1, SPW_OFF_CLEAR, 32'h4);
        rd(SPW_OFF_STATUS, 32'h4);
        clk_en <= 1'b0;
        repeat (3) @(posedge clk);
        clk_en <= 1'b1;
        u_cpu.xfer(1'b1, SPW_OFF_HW_START_SEL, 32'h2);
        u_cpu.xfer(1'b1, SPW_OFF_HW_STOP_SEL, 32'h4);
        hw_sta <= 4'($random(seed)) | 4'h2;
        hw_stp <= 4'($random(seed)) | 4'h4;
        repeat (2) @(posedge clk);
        rd(SPW_OFF_STATUS, 32'h2);
        // Channel 2 held stopped by hardware; CPU start must win one cycle
        u_cpu.xfer(1'b1, cha(2, SPW_CH_COUNT), 32'h0);
        u_cpu.xfer(1'b1, SPW_OFF_START, 32'h4);
        rd(cha(2, SPW_CH_COUNT), 32'h1);
        repeat (3) @(posedge clk);
        chk("reads_left", exp_q.size(), 32'h0);
        give_verdict();
    end
endmodule : spw_top_tb_top
`default_nettype wire
